// ### hdl/stepper_ctrl_regs.sv
// Control-register bank of a stepper driver, reached over a 16-bit serial slave port.
// Assumes the serial pins come from outside the clk domain and are much slower
// than clk; speed_value and full_step_pulse come from logic on clk.
// Notes on behaviour
// - Every control register can be written and read back over the serial port.
// - Each frame returns contents of the addresses received in the last completed frame.
// - First frame after reset returns all zeros, from address zero; the master ignores it.
// - Direction polarity bit set inverts the direction pin.
// - Hold state is active when run/hold pin equals its polarity bit.
// - Writing the soft step bit as one advances the position table one step.
// - H-bridges are enabled only while the bridge enable bit is set.
// - Stall threshold sets stall level; zero disables stall detection.
// - Coil current comes from hold nibble in hold, run nibble in run.
// - Enhanced back-EMF measurement is active while its enable bit is set.
// - With auto diagnostic enabled, a rising bridge enable starts a diagnostic.
// - Two-bit slew select sets switching slope and resets to binary 10.
// - Writing the sleep bit as one places the device in sleep.
// - Period difference above stall timeout triggers a back-EMF stall sample.
// - Back-EMF and stall detection run only while speed is at most threshold.
// - One register holds both undervoltage levels, upper and lower nibble.
// - Bank select bit is prepended to every received 4-bit address.
// - Back-EMF gain select picks scale one half or one quarter.
// - Writes happen only via the upper address nibble; contents return next access.
// - Data shifts out on falling serial clock and is sampled on rising.
// - In sleep only a chip-select falling edge wakes, clearing the sleep bit.
// - Address nibble zero is a no-operation answering all zeros.
`timescale 1ns/1ps
`default_nettype none

module stepper_ctrl_regs
  import stepper_ctrl_pkg::*;
#(
  parameter int TICK_CYCLES = 100,
  parameter int PERIOD_WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic sdi_pin,
  output logic sdo,
  output logic sdo_oe,
  input wire logic direction_pin,
  input wire logic run_hold_pin,
  input wire logic [7:0] speed_value,
  input wire logic full_step_pulse,
  output logic step_direction,
  output logic hold_state,
  output logic soft_step,
  output logic bridges_enabled,
  output logic stall_detect_enable,
  output logic [3:0] stall_level,
  output logic [3:0] coil_current,
  output logic enhanced_backemf_on,
  output logic backemf_measure_enable,
  output logic diag_start,
  output logic [1:0] slew_select,
  output logic sleep_active,
  output logic [2:0] step_mode_select,
  output logic [7:0] stall_timeout,
  output logic backemf_sample,
  output logic [3:0] undervoltage1_level,
  output logic [3:0] undervoltage2_level,
  output logic backemf_gain_quarter,
  output logic [5:0] interrupt_enables,
  output logic [4:0] boost_open_setting
);

  logic [7:0] motion_polarity_control;
  logic [7:0] coil_current_setting;
  logic [7:0] drive_mode_setting;
  logic [7:0] stall_timeout_setting;
  logic [7:0] speed_threshold_setting;
  logic [7:0] undervoltage_levels;
  logic [7:0] bank_gain_interrupt_enables;
  logic [7:0] boost_open_coil_setting;

  // Pin synchronisers; stage 0 feeds only stage 1
  logic [SYNC_STAGES-1:0] cs_sync, sclk_sync, sdi_sync, dir_sync, rhb_sync;
  logic cs_prev, sclk_prev;
  always_ff @(posedge clk) begin
    if (rst) begin
      cs_sync <= '1;
      sclk_sync <= '0;
      sdi_sync <= '0;
      dir_sync <= '0;
      rhb_sync <= '0;
      cs_prev <= 1'b1;
      sclk_prev <= 1'b0;
    end else begin
      cs_sync <= {cs_sync[0], cs_n_pin};
      sclk_sync <= {sclk_sync[0], sclk_pin};
      sdi_sync <= {sdi_sync[0], sdi_pin};
      dir_sync <= {dir_sync[0], direction_pin};
      rhb_sync <= {rhb_sync[0], run_hold_pin};
      cs_prev <= cs_sync[1];
      sclk_prev <= sclk_sync[1];
    end
  end

  logic cs_fall, cs_rise, sclk_rise, sclk_fall, cs_active;
  assign cs_active = ~cs_sync[1];
  assign cs_fall = cs_prev & ~cs_sync[1];
  assign cs_rise = ~cs_prev & cs_sync[1];
  assign sclk_rise = cs_active & ~sclk_prev & sclk_sync[1];
  assign sclk_fall = cs_active & sclk_prev & ~sclk_sync[1];

  // Bank bit on top of a nibble
  function automatic logic [4:0] full_addr(input logic [3:0] nib, input logic bank);
    full_addr = {bank, nib};
  endfunction

  // Register read decode; status and nop addresses answer zero
  function automatic logic [7:0] read_reg(input logic [4:0] a);
    case (a)
      ADDR_MOTION, ADDR_MOTION | 5'h10: read_reg = motion_polarity_control;
      ADDR_CURRENT, ADDR_CURRENT | 5'h10: read_reg = coil_current_setting;
      ADDR_DRIVE, ADDR_DRIVE | 5'h10: read_reg = drive_mode_setting;
      ADDR_TIMEOUT: read_reg = stall_timeout_setting;
      ADDR_SPEED, ADDR_SPEED | 5'h10: read_reg = speed_threshold_setting;
      ADDR_UVOLT, ADDR_UVOLT | 5'h10: read_reg = undervoltage_levels;
      ADDR_BANK, ADDR_BANK | 5'h10: read_reg = bank_gain_interrupt_enables;
      ADDR_BOOST: read_reg = boost_open_coil_setting & BOOST_USED_MASK;
      default: read_reg = 8'h00;
    endcase
  endfunction

  // Shift register: loads the answer, shifts in data on rising clock
  logic [FRAME_BITS-1:0] shifter;
  logic [4:0] bit_count;
  logic frame_live;
  logic [4:0] last_hi, last_lo;
  logic frame_done;
  logic [FRAME_BITS-1:0] answer;
  // A process, not an assign: the function reads registers that are not its arguments
  always_comb begin
    answer = {read_reg(last_hi), read_reg(last_lo)};
  end
  assign frame_done = cs_rise & frame_live & (bit_count[3:0] == 4'h0) & (bit_count != 5'd0);

  always_ff @(posedge clk) begin
    if (rst) begin
      shifter <= '0;
      bit_count <= '0;
      frame_live <= 1'b0;
    end else if (cs_fall) begin
      shifter <= answer;
      bit_count <= '0;
      frame_live <= ~sleep_active; // Frames are lost while asleep
    end else if (sclk_rise) begin
      shifter <= {shifter[FRAME_BITS-2:0], sdi_sync[1]};
      // Wraps every frame so daisy chains of 16-bit multiples still qualify
      bit_count <= {bit_count[4] | (bit_count[3:0] == 4'hf), bit_count[3:0] + 4'h1};
    end
  end

  // Serial output, changing on select fall and falling clock only
  always_ff @(posedge clk) begin
    if (rst) begin
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
    end else begin
      sdo_oe <= cs_active & ~sleep_active;
      if (cs_fall) begin
        sdo <= answer[FRAME_BITS-1];
      end else if (sclk_fall) begin
        sdo <= shifter[FRAME_BITS-1];
      end
    end
  end

  // Address pair remembered for the next answer; zero after reset
  logic [4:0] rx_hi, rx_lo;
  logic write_hit;
  assign rx_hi = full_addr(shifter[15:12], bank_gain_interrupt_enables[BANK_SELECT_BIT]);
  assign rx_lo = full_addr(shifter[11:8], bank_gain_interrupt_enables[BANK_SELECT_BIT]);
  // Only the first nibble writes; status and nop nibbles never do
  assign write_hit = frame_done && shifter[15:12] != ADDR_NOP
    && shifter[15:12] <= ADDR_LAST_CTRL;
  always_ff @(posedge clk) begin
    if (rst) begin
      last_hi <= '0;
      last_lo <= '0;
    end else if (frame_done) begin
      last_hi <= rx_hi;
      last_lo <= rx_lo;
    end
  end

  // Register writes; bank twins share storage, except nibble 4 (timeout in bank 0, boost in bank 1)
  always_ff @(posedge clk) begin
    if (rst) begin
      motion_polarity_control <= RST_MOTION;
      coil_current_setting <= RST_CURRENT;
      drive_mode_setting <= RST_DRIVE;
      stall_timeout_setting <= RST_TIMEOUT;
      speed_threshold_setting <= RST_SPEED;
      undervoltage_levels <= RST_UVOLT;
      bank_gain_interrupt_enables <= RST_BANK;
      boost_open_coil_setting <= RST_BOOST;
    end else begin
      if (write_hit) begin
        case (rx_hi)
          ADDR_MOTION, ADDR_MOTION | 5'h10: motion_polarity_control <= shifter[7:0];
          ADDR_CURRENT, ADDR_CURRENT | 5'h10: coil_current_setting <= shifter[7:0];
          ADDR_DRIVE, ADDR_DRIVE | 5'h10: drive_mode_setting <= shifter[7:0];
          ADDR_TIMEOUT: stall_timeout_setting <= shifter[7:0];
          ADDR_SPEED, ADDR_SPEED | 5'h10: speed_threshold_setting <= shifter[7:0];
          ADDR_UVOLT, ADDR_UVOLT | 5'h10: undervoltage_levels <= shifter[7:0];
          ADDR_BANK, ADDR_BANK | 5'h10: bank_gain_interrupt_enables <= shifter[7:0];
          ADDR_BOOST: boost_open_coil_setting <= shifter[7:0] & BOOST_USED_MASK;
          default: ;
        endcase
      end else if (cs_fall && sleep_active) begin
        // Wake cannot collide with a write: no frame completes while asleep
        drive_mode_setting[SLEEP_BIT] <= 1'b0;
      end
    end
  end

  // Soft step and diagnostic start pulses
  logic bridge_prev;
  always_ff @(posedge clk) begin
    if (rst) begin
      soft_step <= 1'b0;
      diag_start <= 1'b0;
      bridge_prev <= 1'b0;
    end else begin
      soft_step <= write_hit && (rx_hi[3:0] == ADDR_MOTION[3:0])
        && shifter[SOFT_STEP_BIT];
      bridge_prev <= motion_polarity_control[BRIDGE_EN_BIT];
      diag_start <= drive_mode_setting[AUTO_DIAG_BIT]
        & motion_polarity_control[BRIDGE_EN_BIT] & ~bridge_prev;
    end
  end

  // Decoded controls toward the motor logic
  logic speed_ok, hold_now;
  assign speed_ok = speed_value <= speed_threshold_setting;
  assign hold_now = ~(rhb_sync[1] ^ motion_polarity_control[RUN_HOLD_POL_BIT]);
  always_ff @(posedge clk) begin
    if (rst) begin
      step_direction <= 1'b0;
      hold_state <= 1'b0;
      bridges_enabled <= 1'b0;
      stall_detect_enable <= 1'b0;
      stall_level <= '0;
      coil_current <= '0;
      enhanced_backemf_on <= 1'b0;
      backemf_measure_enable <= 1'b0;
      slew_select <= '0;
      sleep_active <= 1'b0;
      step_mode_select <= '0;
      stall_timeout <= '0;
      undervoltage1_level <= '0;
      undervoltage2_level <= '0;
      backemf_gain_quarter <= 1'b0;
      interrupt_enables <= '0;
      boost_open_setting <= '0;
    end else begin
      step_direction <= dir_sync[1] ^ motion_polarity_control[DIR_POL_BIT];
      hold_state <= hold_now;
      // Sleep overrides the bridge enable, whose value is kept
      bridges_enabled <= motion_polarity_control[BRIDGE_EN_BIT]
        & ~drive_mode_setting[SLEEP_BIT];
      stall_detect_enable <= (motion_polarity_control[3:0] != 4'h0) & speed_ok;
      stall_level <= motion_polarity_control[3:0];
      coil_current <= hold_now ? coil_current_setting[7:4]
        : coil_current_setting[3:0];
      enhanced_backemf_on <= drive_mode_setting[ENH_BEMF_BIT];
      backemf_measure_enable <= speed_ok;
      slew_select <= drive_mode_setting[5:4];
      sleep_active <= drive_mode_setting[SLEEP_BIT];
      step_mode_select <= drive_mode_setting[2:0];
      stall_timeout <= stall_timeout_setting;
      undervoltage1_level <= undervoltage_levels[7:4];
      undervoltage2_level <= undervoltage_levels[3:0];
      backemf_gain_quarter <= bank_gain_interrupt_enables[GAIN_SELECT_BIT];
      interrupt_enables <= bank_gain_interrupt_enables[5:0];
      boost_open_setting <= boost_open_coil_setting[4:0];
    end
  end

  // Full-step period in ticks, compared with the previous period
  logic [15:0] tick_count;
  logic [PERIOD_WIDTH-1:0] period_now, period_prev, period_diff;
  logic tick;
  assign tick = tick_count == 16'(TICK_CYCLES - 1);
  assign period_diff = period_now > period_prev ? period_now - period_prev
    : period_prev - period_now;
  always_ff @(posedge clk) begin
    if (rst) begin
      tick_count <= '0;
      period_now <= '0;
      period_prev <= '0;
      backemf_sample <= 1'b0;
    end else begin
      tick_count <= tick ? 16'h0000 : tick_count + 16'h0001;
      backemf_sample <= 1'b0;
      if (full_step_pulse) begin
        period_prev <= period_now;
        period_now <= '0;
        // Stall is verified only where detection is permitted
        backemf_sample <= stall_detect_enable
          && period_diff > PERIOD_WIDTH'(stall_timeout_setting);
      end else if (tick && period_now != '1) begin
        period_now <= period_now + 1'b1; // Saturates so long stops stay large
      end
    end
  end

endmodule

`default_nettype wire

// ### hdl/stepper_ctrl_pkg.sv
// Constants for the stepper driver control-register bank and its serial port.
// Assumes 16-bit frames: command byte followed by data byte, MSB first.
package stepper_ctrl_pkg;
  // Full 5-bit register addresses (bank bit on top), then 4-bit nibble limits
  localparam logic [4:0] ADDR_MOTION = 5'h01;
  localparam logic [4:0] ADDR_CURRENT = 5'h02;
  localparam logic [4:0] ADDR_DRIVE = 5'h03;
  localparam logic [4:0] ADDR_TIMEOUT = 5'h04;
  localparam logic [4:0] ADDR_SPEED = 5'h05;
  localparam logic [4:0] ADDR_UVOLT = 5'h06;
  localparam logic [4:0] ADDR_BANK = 5'h07;
  localparam logic [4:0] ADDR_BOOST = 5'h14;
  localparam logic [3:0] ADDR_NOP = 4'h0;
  localparam logic [3:0] ADDR_LAST_CTRL = 4'h7;
  // Reset values
  localparam logic [7:0] RST_MOTION = 8'h00;
  localparam logic [7:0] RST_CURRENT = 8'h00;
  localparam logic [7:0] RST_DRIVE = 8'h20;
  localparam logic [7:0] RST_TIMEOUT = 8'h10;
  localparam logic [7:0] RST_SPEED = 8'h00;
  localparam logic [7:0] RST_UVOLT = 8'h00;
  localparam logic [7:0] RST_BANK = 8'h00;
  localparam logic [7:0] RST_BOOST = 8'h04;
  // Field positions
  localparam int DIR_POL_BIT = 7;
  localparam int RUN_HOLD_POL_BIT = 6;
  localparam int SOFT_STEP_BIT = 5;
  localparam int BRIDGE_EN_BIT = 4;
  localparam int ENH_BEMF_BIT = 7;
  localparam int AUTO_DIAG_BIT = 6;
  localparam int SLEEP_BIT = 3;
  localparam int BANK_SELECT_BIT = 7;
  localparam int GAIN_SELECT_BIT = 6;
  localparam logic [7:0] BOOST_USED_MASK = 8'h1f;
  // Frame geometry and synchroniser depth
  localparam int FRAME_BITS = 16;
  localparam int SYNC_STAGES = 2;
endpackage

// ### testbench/stepper_regs_checker.sv
// Assertions on the stepper control bank, seen from its top-level ports.
// Assumes one clk domain and synchronous active-high rst.
`timescale 1ns/1ps
`default_nettype none
module stepper_regs_checker #(
  parameter int TICK_CYCLES = 100
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cs_n_pin,
  input wire logic sclk_pin,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic full_step_pulse,
  input wire logic soft_step,
  input wire logic bridges_enabled,
  input wire logic stall_detect_enable,
  input wire logic [3:0] stall_level,
  input wire logic backemf_measure_enable,
  input wire logic diag_start,
  input wire logic [1:0] slew_select,
  input wire logic sleep_active,
  input wire logic backemf_sample
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // Serial clock high long enough that no falling edge is still in the synchroniser
  sequence sclk_high_settled;
    (sclk_pin && !cs_n_pin) [*6];
  endsequence
  // A released select pin, held for longer than the synchroniser delay
  sequence cs_released;
    cs_n_pin [*5];
  endsequence
  a_bridges_sleep_off: assert property (sleep_active |-> !bridges_enabled)
    else $error("bridges enabled while asleep");
  a_stall_zero_off: assert property (stall_level == 4'h0 |-> !stall_detect_enable)
    else $error("stall detection on with zero threshold");
  a_speed_gate: assert property (stall_detect_enable |-> backemf_measure_enable)
    else $error("stall detection on above speed threshold");
  a_sample_cause: assert property (backemf_sample |-> $past(full_step_pulse) && $past(stall_detect_enable))
    else $error("back-emf sample without full step or enable");
  a_soft_step_pulse: assert property (soft_step |=> !soft_step)
    else $error("soft step longer than one cycle");
  a_diag_pulse: assert property (diag_start |-> !$past(diag_start))
    else $error("diagnostic start longer than one cycle");
  a_sdo_hold_high: assert property (sclk_high_settled |=> $stable(sdo))
    else $error("serial output moved while clock high");
  a_oe_released: assert property (cs_released |-> !sdo_oe)
    else $error("serial output driven while deselected");
  a_oe_needs_select: assert property ($rose(sdo_oe) |-> !cs_n_pin)
    else $error("serial output enabled without select");
  a_slew_reset: assert property ($fell(rst) |-> ##[1:2] (slew_select == 2'b10))
    else $error("slew select not at reset value");
endmodule
`default_nettype wire

// ### testbench/spi_master_model.sv
// Microcontroller model acting as serial master towards the register bank.
// Assumes the bench calls xfer; sclk idles low and stands still between frames.
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
  input wire logic clk,
  input wire logic sdo,
  input wire logic sdo_oe,
  output logic cs_n,
  output logic sclk,
  output logic sdi
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b1;
  end
  // One frame of nbits; half is the sclk half period in clk cycles, 4 or more
  task automatic xfer(input int nbits, input int half, input logic [15:0] cmd,
                      output logic [15:0] resp);
    resp = 16'h0000;
    @(posedge clk) #1 cs_n = 1'b0;
    repeat (half) @(posedge clk);
    #1; // First data bit also changes off the clk edge
    for (int i = nbits - 1; i >= 0; i--) begin
      sdi = cmd[i];
      repeat (half) @(posedge clk);
      #1 sclk = 1'b1;
      // Undriven line reads as a flipping level, never a stale bit
      resp = {resp[14:0], sdo_oe ? sdo : ~resp[0]};
      repeat (half) @(posedge clk);
      #1 sclk = 1'b0;
    end
    repeat (half) @(posedge clk);
    #1 cs_n = 1'b1;
    sdi = ~sdi; // Released data line shows the inverse, not the last bit
    repeat (5) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the stepper control-register bank.
// Assumes the master model drives the serial pins; other inputs come from here.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import stepper_ctrl_pkg::*;
  localparam int TICKS = 2;
  localparam int LIMIT = 30000;
  logic clk, rst, cs_n_pin, sclk_pin, sdi_pin, direction_pin, run_hold_pin, full_step_pulse;
  logic sdo, sdo_oe, step_direction, hold_state, soft_step, bridges_enabled, stall_detect_enable;
  logic enhanced_backemf_on, backemf_measure_enable, diag_start, sleep_active, backemf_sample;
  logic backemf_gain_quarter;
  logic [3:0] stall_level, coil_current, undervoltage1_level, undervoltage2_level;
  logic [7:0] speed_value, stall_timeout;
  logic [1:0] slew_select;
  logic [2:0] step_mode_select;
  logic [5:0] interrupt_enables;
  logic [4:0] boost_open_setting;
  logic [15:0] r;
  int miscompares = 0, samples_checked = 0, cycles = 0, n_soft = 0, n_diag = 0, n_samp = 0;
  int c0 = 0, half = 4;
  stepper_ctrl_regs #(.TICK_CYCLES(TICKS)) dut_u (.clk, .rst, .cs_n_pin, .sclk_pin, .sdi_pin,
    .sdo, .sdo_oe, .direction_pin, .run_hold_pin, .speed_value, .full_step_pulse, .step_direction,
    .hold_state, .soft_step, .bridges_enabled, .stall_detect_enable, .stall_level, .coil_current,
    .enhanced_backemf_on, .backemf_measure_enable, .diag_start, .slew_select, .sleep_active,
    .step_mode_select, .stall_timeout, .backemf_sample, .undervoltage1_level,
    .undervoltage2_level, .backemf_gain_quarter, .interrupt_enables, .boost_open_setting);
  spi_master_model master_u (.clk, .sdo, .sdo_oe, .cs_n(cs_n_pin), .sclk(sclk_pin),
    .sdi(sdi_pin));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Pulse counters and hang guard
  always @(posedge clk) begin
    cycles++;
    if (soft_step === 1'b1) n_soft++;
    if (diag_start === 1'b1) n_diag++;
    if (backemf_sample === 1'b1) n_samp++;
    if (cycles == LIMIT) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic send(input logic [15:0] cmd);
    master_u.xfer(16, half, cmd, r);
  endtask
  task automatic frame(input logic [15:0] cmd, input logic [15:0] exp);
    send(cmd);
    check(r, exp);
  endtask
  // Pins cross a synchroniser, so outputs lag a few cycles
  task automatic settle();
    repeat (5) @(posedge clk);
    #1;
  endtask
  task automatic step_after(input int n);
    repeat (n) @(posedge clk);
    #1 full_step_pulse = 1'b1;
    @(posedge clk) #1 full_step_pulse = 1'b0;
  endtask
  task automatic t_write();
    logic [7:0] v [1:6];
    v = '{8'hd3, 8'h5a, 8'h72, 8'h05, 8'h80, 8'hc4};
    send(16'h1200);
    frame(16'h8300, 16'h0000);
    frame(16'h8400, 16'h0020);
    frame(16'h5600, 16'h0010);
    frame(16'h7000, 16'h0000);
    frame(16'h0800, 16'h0000);
    frame(16'h0000, 16'h0000);
    for (int a = 1; a <= 6; a++) begin
      frame({a[3:0], 4'h0, v[a]}, {(a == 1) ? 8'h00 : v[a - 1], 8'h00});
    end
    frame(16'h0155, 16'hc400);
    frame(16'h0000, 16'h00d3);
    settle();
    check({step_direction, hold_state, coil_current, stall_level, slew_select, step_mode_select},
          {1'b1, 1'b1, 4'h5, 4'h3, 2'b11, 3'h2});
    run_hold_pin = 1'b0;
    direction_pin = 1'b1;
    settle();
    check({step_direction, hold_state, coil_current}, {1'b0, 1'b0, 4'ha});
    check({stall_timeout, undervoltage1_level, undervoltage2_level, bridges_enabled,
           stall_detect_enable, backemf_measure_enable}, {16'h05c4, 3'b111});
    send(16'h10e3);
    send(16'h10d3);
    settle();
    check(n_soft, 1);
    check(n_diag, 1);
    $display("write test done");
  endtask
  task automatic t_bank();
    send(16'h70bf);
    settle();
    check({backemf_gain_quarter, interrupt_enables}, {1'b0, 6'h3f});
    send(16'h40ff);
    frame(16'h1093, 16'h1f00);
    send(16'h7040);
    frame(16'h0400, 16'h4000);
    frame(16'h0100, 16'h0005);
    frame(16'h0000, 16'h0093);
    check({backemf_gain_quarter, interrupt_enables, boost_open_setting},
          {1'b1, 6'h00, 5'h1f});
    half = 7;
    master_u.xfer(15, half, 16'h1000, r);
    send(16'h0100);
    frame(16'h0000, 16'h0093);
    half = 4;
    $display("bank test done");
  endtask
  task automatic t_sleep();
    send(16'h30fa);
    settle();
    check({sleep_active, bridges_enabled}, 2'b10);
    send(16'h1000);
    settle();
    check({sleep_active, bridges_enabled, enhanced_backemf_on}, 3'b011);
    send(16'h0300);
    frame(16'h0000, 16'h00f2);
    $display("sleep test done");
  endtask
  task automatic t_stall();
    step_after(2);
    step_after(20);
    repeat (3) @(posedge clk);
    c0 = n_samp;
    step_after(20);
    step_after(200);
    repeat (3) @(posedge clk);
    check(n_samp, c0 + 1);
    #1 speed_value = 8'h90;
    step_after(20);
    repeat (3) @(posedge clk);
    check(n_samp, c0 + 1);
    check({stall_detect_enable, backemf_measure_enable}, 2'b00);
    $display("stall test done");
  endtask
  initial begin
    rst = 1'b1;
    direction_pin = 1'b0;
    run_hold_pin = 1'b1;
    full_step_pulse = 1'b0;
    speed_value = 8'h40;
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    repeat (6) @(posedge clk);
    t_write();
    t_bank();
    t_sleep();
    t_stall();
    end_of_test();
  end
endmodule
bind stepper_ctrl_regs stepper_regs_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_u (.clk, .rst,
  .cs_n_pin, .sclk_pin, .sdo, .sdo_oe, .full_step_pulse, .soft_step, .bridges_enabled,
  .stall_detect_enable, .stall_level, .backemf_measure_enable, .diag_start, .slew_select,
  .sleep_active, .backemf_sample);
`default_nettype wire
